/* hdl/bwl_monitor.sv */
// Purpose: per-channel request spacing and work-unit cycle budget monitor
// Assumes: APB slave, one pclk domain, channel logic outside issues requests
// Notes:   no wait state on any APB access, reads of status clear its flags but keep the cause
//
// Summary of operation
// R1 - Two requests to the crossbar are at least the spacing count cycles apart.
// R2 - A spacing count of zero lets a request go every cycle for sizes up to the bus width.
// R3 - A spacing count of all ones stops every request until it changes.
// R4 - Rate is capped by both bus width (burst beats) and size over spacing.
// R5 - The remaining counter reloads from budget on config write, unit end and wrap.
// R6 - The remaining counter drops by one each cycle a work unit is active.
// R7 - Reaching zero inside an active unit raises the error flag with cause six.
// R8 - An expired counter sits at zero until the next reload.
// R9 - Expiry does not halt the channel while other errors do.
// R10 - A budget of zero switches the monitor off.
// R11 - The fast copy stream uses channels 43 and 44 on a 64-bit bus.
// R12 - Software splits unaligned copies into head, 32-byte middle and tail.
// R13 - A work unit start not aligned to transfer size raises the error flag.
// R14 - Transfer size is 1 to 32 bytes, wider than the bus goes as a burst.
// R15 - The spacing counter restarts at each request and holds the next one.
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`include "bwl_params.svh"
`timescale 1ns/1ps
`default_nettype none
module bwl_monitor
  import bwl_pkg::*;
#(
  parameter int BUS_BITS = 64,
  parameter int SRC_CHAN = 43,
  parameter int DST_CHAN = 44
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Channel side
  input  wire logic        req_want,
  input  wire wu_t         wu,
  output logic             req_strobe,
  output logic      [2:0]  req_size,
  output logic      [5:0]  req_beats,
  output logic             chan_halt,
  // Interrupt
  output logic             irq
);
  localparam logic [5:0] BUS_BYTES = 6'(BUS_BITS / 8);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [5:0] size_bytes(input logic [2:0] code);
    size_bytes = 6'h01 << code;
  endfunction : size_bytes

  // R14 burst beats
  function automatic logic [5:0] beats_of(input logic [2:0] code);
    beats_of = (size_bytes(code) > BUS_BYTES) ? 6'(size_bytes(code) / BUS_BYTES) : 6'h01;
  endfunction : beats_of

  function automatic logic mapped(input logic [7:0] a);
    mapped = a == `OFF_CFG || a == `OFF_SPACING || a == `OFF_BUDGET ||
             a == `OFF_REMAIN || a == `OFF_STAT || a == `OFF_MASK || a == `OFF_CHAN;
  endfunction : mapped

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic [2:0]          size_r, size_nxt;
  logic [15:0]         spacing_r, spacing_nxt;
  logic [31:0]         budget_r, budget_nxt;
  logic [31:0]         remain_r, remain_nxt;
  logic [`EV_W-1:0]    stat_r, stat_nxt;
  logic [`EV_W-1:0]    mask_r, mask_nxt;
  logic [3:0]          cause_r, cause_nxt;
  logic [31:0]         prdata_nxt;
  logic                pready_nxt, pslverr_nxt;
  logic [15:0]         gap_r, gap_nxt;
  logic                strobe_nxt;
  chan_state_t         st_r, st_nxt;
  logic                wr_done, rd_done, cfg_wr, allowed, issue;
  logic                ev_mon, ev_align;
  logic [15:0]         gap_len;

  assign wr_done = psel && penable && pready && pwrite;
  assign rd_done = psel && penable && pready && !pwrite;
  assign cfg_wr  = wr_done && paddr == `OFF_CFG;

  // ---------------------------------------------------------------
  // APB access
  // ---------------------------------------------------------------
  always_comb begin
    size_nxt    = size_r;
    spacing_nxt = spacing_r;
    budget_nxt  = budget_r;
    mask_nxt    = mask_r;
    pready_nxt  = 1'b0;
    pslverr_nxt = 1'b0;
    prdata_nxt  = prdata;
    if (psel && !penable) begin
      pready_nxt  = 1'b1;
      pslverr_nxt = !mapped(paddr);
      prdata_nxt  = 32'h0000_0000;
      if (!pwrite) begin
        case (paddr)
          `OFF_CFG:     prdata_nxt = {29'h0, size_r};
          `OFF_SPACING: prdata_nxt = {16'h0, spacing_r};
          `OFF_BUDGET:  prdata_nxt = budget_r;
          `OFF_REMAIN:  prdata_nxt = remain_r;
          `OFF_STAT:    prdata_nxt = {24'h0, cause_r, 2'b00, stat_r};
          `OFF_MASK:    prdata_nxt = {30'h0, mask_r};
          // R11 stream identity
          `OFF_CHAN:    prdata_nxt = {8'(BUS_BITS), 8'h00, 8'(DST_CHAN), 8'(SRC_CHAN)};
          default:      prdata_nxt = 32'h0000_0000;
        endcase
      end
    end
    if (wr_done) begin
      case (paddr)
        `OFF_CFG:
          if (pwdata[2:0] <= `SIZE_MAX) size_nxt = pwdata[2:0];
        `OFF_SPACING: spacing_nxt = pwdata[15:0];
        `OFF_BUDGET:  budget_nxt = pwdata;
        `OFF_MASK:    mask_nxt = pwdata[`EV_W-1:0];
        default:      ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      size_r    <= `SIZE_RST;
      spacing_r <= `SPACING_RST;
      budget_r  <= `BUDGET_RST;
      mask_r    <= '0;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      prdata    <= 32'h0000_0000;
    end else begin
      size_r    <= size_nxt;
      spacing_r <= spacing_nxt;
      budget_r  <= budget_nxt;
      mask_r    <= mask_nxt;
      pready    <= pready_nxt;
      pslverr   <= pslverr_nxt;
      prdata    <= prdata_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Request spacing
  // ---------------------------------------------------------------
  // R2 R4 gap is the larger of burst beats and spacing
  assign gap_len = (spacing_r > 16'(beats_of(size_r))) ? spacing_r : 16'(beats_of(size_r));
  // R3 all ones stops requests
  assign allowed = gap_r == 16'h0000 && spacing_r != `SPACING_STOP && st_r == CH_RUN;
  assign issue   = req_want && allowed;

  always_comb begin
    gap_nxt    = gap_r;
    strobe_nxt = issue;
    // R15 restart after a request
    if (issue)
      gap_nxt = gap_len - 16'h0001;
    // R1 count out the gap
    else if (gap_r != 16'h0000)
      gap_nxt = gap_r - 16'h0001;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_r      <= 16'h0000;
      req_strobe <= 1'b0;
      req_size   <= `SIZE_RST;
      req_beats  <= 6'h01;
    end else begin
      gap_r      <= gap_nxt;
      req_strobe <= strobe_nxt;
      req_size   <= size_r;
      req_beats  <= beats_of(size_r);
    end
  end

  // ---------------------------------------------------------------
  // Budget monitor and errors
  // ---------------------------------------------------------------
  // R7 expiry only inside an unfinished unit; R10 zero budget is off
  assign ev_mon = wu.active && !wu.done && !wu.wrap && !cfg_wr &&
                  budget_r != 32'h0000_0000 && remain_r == 32'h0000_0001;
  // R13 misaligned start
  assign ev_align = wu.start && ((wu.addr[5:0] & (size_bytes(size_r) - 6'h01)) != 6'h00);

  always_comb begin
    remain_nxt = remain_r;
    stat_nxt   = stat_r;
    cause_nxt  = cause_r;
    st_nxt     = st_r;
    // R5 reload sources win over counting
    if (cfg_wr || wu.done || wu.wrap)
      remain_nxt = budget_r;
    // R6 one per active cycle; R8 stop at zero
    else if (wu.active && remain_r != 32'h0000_0000)
      remain_nxt = remain_r - 32'h0000_0001;
    // Clear only what the read returned, so a set after the snapshot survives
    if (rd_done && paddr == `OFF_STAT)
      stat_nxt = stat_r & ~prdata[`EV_W-1:0];
    // R7 flag and cause; set beats a same-cycle clear
    if (ev_mon) begin
      stat_nxt[`STAT_MON] = 1'b1;
      cause_nxt           = `CAUSE_MON;
    end
    if (ev_align) begin
      stat_nxt[`STAT_ALIGN] = 1'b1;
      cause_nxt             = `CAUSE_ALIGN;
    end
    // R9 only alignment errors halt
    case (st_r)
      CH_RUN:  if (ev_align) st_nxt = CH_HALT;
      CH_HALT: if (cfg_wr) st_nxt = CH_RUN;
      default: st_nxt = CH_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remain_r  <= `BUDGET_RST;
      stat_r    <= '0;
      cause_r   <= 4'h0;
      st_r      <= CH_RUN;
      chan_halt <= 1'b0;
      irq       <= 1'b0;
    end else begin
      remain_r  <= remain_nxt;
      stat_r    <= stat_nxt;
      cause_r   <= cause_nxt;
      st_r      <= st_nxt;
      chan_halt <= st_nxt == CH_HALT;
      irq       <= |(stat_nxt & mask_r);
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // R1 spacing between strobes
  a_strobe_gap: assert property (req_strobe && spacing_r == 16'h0003 && size_r <= 3'h3
                                 |=> !req_strobe [*2])
    else $error("strobes closer than spacing");
  // R2 back to back allowed
  a_zero_gap: assert property (issue && spacing_r == 16'h0000 && size_r <= 3'h3
                               |=> allowed || st_r != CH_RUN)
    else $error("zero spacing still waits");
  // R3 stop value
  a_stop_all: assert property (spacing_r == `SPACING_STOP && $past(spacing_r) == `SPACING_STOP
                               |-> !req_strobe)
    else $error("request under stop value");
  // R4 burst needs its beats
  a_burst_gap: assert property (issue && size_r == 3'h5 && spacing_r == 16'h0000
                                |=> !issue)
    else $error("burst gap too short");
  // R5 reload on unit end
  a_reload_end: assert property (wu.done |=> remain_r == $past(budget_r))
    else $error("no reload at unit end");
  // R6 count down
  a_count_down: assert property (wu.active && !wu.done && !wu.wrap && !cfg_wr && remain_r > 32'h1
                                 |=> remain_r == $past(remain_r) - 32'h1)
    else $error("counter missed a step");
  // R7 expiry flag and cause
  a_expiry_flag: assert property (ev_mon |=> stat_r[`STAT_MON] && cause_r == `CAUSE_MON ##1 1)
    else $error("expiry not flagged");
  // R8 hold zero
  a_hold_zero: assert property (remain_r == 32'h0 && !wu.done && !wu.wrap && !cfg_wr
                                |=> remain_r == 32'h0)
    else $error("counter left zero");
  // R9 expiry keeps running
  a_no_halt: assert property (ev_mon && !ev_align && st_r == CH_RUN |=> !chan_halt)
    else $error("expiry halted channel");
  // R10 disabled monitor
  a_mon_off: assert property (budget_r == 32'h0 && !stat_r[`STAT_MON] |=> !stat_r[`STAT_MON])
    else $error("monitor fired while off");
  // R13 misaligned start halts
  a_align_err: assert property (ev_align |=> stat_r[`STAT_ALIGN] && chan_halt)
    else $error("misalign not caught");
  c_expiry: cover property (ev_mon);
  c_spaced: cover property (req_strobe && spacing_r > 16'h0002);
  c_align:  cover property (ev_align);
  c_irq:    cover property (irq);
endmodule : bwl_monitor
`default_nettype wire

/* include/bwl_params.svh */
// Purpose: offsets, fields, reset values and codes for the limiter/monitor
// Assumes: 32-bit APB, one word per register
// Notes:   byte addresses
`ifndef BWL_PARAMS_SVH
`define BWL_PARAMS_SVH
`define OFF_CFG      8'h00
`define OFF_SPACING  8'h04
`define OFF_BUDGET   8'h08
`define OFF_REMAIN   8'h0C
`define OFF_STAT     8'h10
`define OFF_MASK     8'h14
`define OFF_CHAN     8'h18
`define CFG_SIZE_LSB 0
`define CFG_SIZE_W   3
`define STAT_MON     0
`define STAT_ALIGN   1
`define STAT_CAUSE   4
`define EV_W         2
`define CAUSE_MON    4'h6
`define CAUSE_ALIGN  4'h1
`define SPACING_STOP 16'hFFFF
`define SPACING_RST  16'h0000
`define BUDGET_RST   32'h0000_0000
`define SIZE_RST     3'h5
`define SIZE_MAX     3'h5
`endif

/* include/bwl_pkg.sv */
// Purpose: shared types for the bandwidth limiter/monitor
// Assumes: nothing
// Notes:   work-unit indications travel as one struct
package bwl_pkg;
  typedef struct packed {
    logic        start;
    logic        active;
    logic        done;
    logic        wrap;
    logic [31:0] addr;
  } wu_t;
  typedef enum logic [1:0] {CH_RUN, CH_HALT} chan_state_t;
endpackage : bwl_pkg

/* sim/dma_bandwidth_limit_monitor_tb.sv */
// Purpose: self-checking bench for the bandwidth limiter and monitor
// Assumes: bwl_pkg compiled first, bwl_params.svh on the include path
// Notes:   levels sampled at the falling edge; bus answers taken at the rising edge
`include "bwl_params.svh"
`timescale 1ns/1ps
`default_nettype none
module dma_bandwidth_limit_monitor_tb
  import bwl_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic        pready, pslverr, req_want, req_strobe, chan_halt, irq, e;
  logic        go = 1'b0;
  logic        clr = 1'b0;
  logic [2:0]  req_size;
  logic [5:0]  req_beats;
  wu_t         wu = '0;
  int          cnt, min_gap;
  int          fail_count = 0;
  int          tests_run = 0;
  always #5 pclk = ~pclk;
  bwl_monitor dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .req_want(req_want), .wu(wu), .req_strobe(req_strobe),
    .req_size(req_size), .req_beats(req_beats), .chan_halt(chan_halt), .irq(irq));
  xbar_model far_u (.pclk(pclk), .presetn(presetn), .go(go), .clr(clr),
    .req_strobe(req_strobe), .req_want(req_want), .cnt(cnt), .min_gap(min_gap));
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // APB master, request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16) begin
      @(posedge pclk);
      n++;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      fail_count++;
      conclude();
    end
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rd
  // Gap 0 means no strobe may appear at all
  task automatic rate(input logic [2:0] sz, input logic [15:0] sp, input int gap);
    wr(`OFF_CFG, {29'h0, sz});
    wr(`OFF_SPACING, {16'h0, sp});
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    go <= 1'b1;
    repeat (40) @(posedge pclk);
    go <= 1'b0;
    repeat (4) @(posedge pclk);
    if (gap == 0) chk(cnt, 32'h0);
    else chk(min_gap, gap);
  endtask : rate
  task automatic active(input int n);
    wu.active <= 1'b1;
    repeat (n) @(posedge pclk);
    wu.active <= 1'b0;
  endtask : active
  // Start pulse, then settle past the halt register
  task automatic start_unit(input logic [31:0] a);
    wu.start <= 1'b1;
    wu.addr <= a;
    @(posedge pclk);
    wu.start <= 1'b0;
    repeat (2) @(negedge pclk);
  endtask : start_unit
  // --------------------------------
  // Main sequence
  // --------------------------------
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(`OFF_CFG, 32'h0000_0005);
    rd(`OFF_SPACING, 32'h0000_0000);
    rd(`OFF_BUDGET, 32'h0000_0000);
    rd(`OFF_CHAN, 32'h4000_2C2B);
    rd(8'h1C, 32'h0000_0000);
    chk(e, 32'h1);
    $display("test registers finished");
    rate(3'h3, 16'h0000, 1);
    rate(3'h3, 16'h0003, 3);
    rate(3'h5, 16'h0000, 4);
    rate(3'h5, 16'h0006, 6);
    rate(3'h3, 16'hFFFF, 0);
    rate(3'h3, 16'h0000, 1);
    $display("test spacing finished");
    for (int s = 0; s < 6; s++) begin
      wr(`OFF_CFG, s);
      repeat (2) @(negedge pclk);
      chk(req_size, s);
      chk(req_beats, (s > 3) ? (1 << s) / 8 : 1);
    end
    wr(`OFF_CFG, 32'h0000_0007);
    repeat (2) @(negedge pclk);
    chk(req_size, 32'h5);
    $display("test sizes finished");
    wr(`OFF_MASK, 32'h0000_0003);
    wr(`OFF_BUDGET, 32'h0000_0003);
    wr(`OFF_CFG, 32'h0000_0003);
    rd(`OFF_REMAIN, 32'h0000_0003);
    clr <= 1'b1;
    go <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    active(5);
    go <= 1'b0;
    repeat (3) @(negedge pclk);
    chk(irq, 32'h1);
    chk(chan_halt, 32'h0);
    chk(cnt > 4, 32'h1);
    rd(`OFF_REMAIN, 32'h0000_0000);
    rd(`OFF_STAT, 32'h0000_0061);
    repeat (2) @(negedge pclk);
    chk(irq, 32'h0);
    @(posedge pclk);
    wu.done <= 1'b1;
    @(posedge pclk);
    wu.done <= 1'b0;
    rd(`OFF_REMAIN, 32'h0000_0003);
    active(2);
    rd(`OFF_REMAIN, 32'h0000_0001);
    wu.wrap <= 1'b1;
    @(posedge pclk);
    wu.wrap <= 1'b0;
    rd(`OFF_REMAIN, 32'h0000_0003);
    $display("test monitor finished");
    // Budget cleared without a reload, so the counter still runs out
    wr(`OFF_BUDGET, 32'h0000_0000);
    active(8);
    rd(`OFF_REMAIN, 32'h0000_0000);
    rd(`OFF_STAT, 32'h0000_0060);
    chk(irq, 32'h0);
    $display("test zero budget finished");
    wr(`OFF_MASK, 32'h0000_0000);
    start_unit(32'h0000_0004);
    chk(chan_halt, 32'h1);
    chk(irq, 32'h0);
    wr(`OFF_MASK, 32'h0000_0002);
    repeat (2) @(negedge pclk);
    chk(irq, 32'h1);
    rd(`OFF_STAT, 32'h0000_0012);
    wr(`OFF_CFG, 32'h0000_0003);
    start_unit(32'h0000_0008);
    chk(chan_halt, 32'h0);
    rd(`OFF_STAT, 32'h0000_0010);
    // Split copy: byte-sized head, then a 32-byte aligned middle
    wr(`OFF_CFG, 32'h0000_0000);
    start_unit(32'h0000_0003);
    chk(chan_halt, 32'h0);
    wr(`OFF_CFG, 32'h0000_0005);
    start_unit(32'h0000_0020);
    chk(chan_halt, 32'h0);
    rd(`OFF_STAT, 32'h0000_0010);
    $display("test misalign finished");
    conclude();
  end
endmodule : dma_bandwidth_limit_monitor_tb
`default_nettype wire

/* sim/xbar_model.sv */
// Purpose: crossbar-side partner, raises requests and measures spacing
// Assumes: one pclk domain shared with the channel
// Notes:   min_gap is the closest pair of strobes since the last clear
`timescale 1ns/1ps
`default_nettype none
module xbar_model (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Bench control
  input  wire logic go,
  input  wire logic clr,
  // Channel side
  input  wire logic req_strobe,
  output var  logic req_want,
  // Observations
  output var int    cnt,
  output var int    min_gap
);
  int since;
  // Requests wanted back to back, so spacing comes only from the channel
  assign req_want = go;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn || clr) begin
      cnt <= 0;
      min_gap <= 999;
      since <= 999;
    end else if (req_strobe) begin
      cnt <= cnt + 1;
      if (since < min_gap) min_gap <= since;
      since <= 1;
    end else if (since < 999) begin
      since <= since + 1;
    end
  end
endmodule : xbar_model
`default_nettype wire
